// ---- rtl/rnsc_regs.svh ----
// timing constants and start-up codes for the reset and start-up config block
`ifndef RNSC_REGS_SVH
`define RNSC_REGS_SVH
// least recognised reset pulse: 100 ns plus 2 cpu clocks
`define RNSC_RST_MIN_NS      100
`define RNSC_CLK_PERIOD_NS   8
`define RNSC_RST_EXTRA_CLKS  2
`define RNSC_RST_MIN_CYCLES  ((`RNSC_RST_MIN_NS + `RNSC_CLK_PERIOD_NS - 1) / \
                              `RNSC_CLK_PERIOD_NS + `RNSC_RST_EXTRA_CLKS)
// code latched when the debug-reset input is low at reset end
`define RNSC_CFG_DEFAULT     4'hf
`endif

// ---- rtl/rnsc_pkg.sv ----
// types of the reset and start-up config block
package rnsc_pkg;
    typedef enum logic [4:0] {
        RNSC_MODE_INTERNAL = 5'h01,
        RNSC_MODE_SER_BOOT = 5'h02,
        RNSC_MODE_CAN_BOOT = 5'h04,
        RNSC_MODE_ADAPT    = 5'h08,
        RNSC_MODE_TEST     = 5'h10
    } rnsc_mode_t;

    // pin order: cfg5_hi, cfg4_hi, cfg5_p9, cfg4_p9
    typedef struct packed {
        logic cfg5_hi;
        logic cfg4_hi;
        logic cfg5_p9;
        logic cfg4_p9;
    } rnsc_cfg_t;

    typedef enum logic [2:0] {
        RNSC_ST_RUN   = 3'h1,
        RNSC_ST_RESET = 3'h2,
        RNSC_ST_PDOWN = 3'h4
    } rnsc_state_t;
endpackage

// ---- rtl/rnsc_top.sv ----
// reset entry, nmi trap request and start-up configuration latch
`timescale 1ns/100ps
`include "rnsc_regs.svh"
module rnsc_top #(
    parameter int unsigned RST_MIN_CYCLES = `RNSC_RST_MIN_CYCLES
) (
    input  wire logic               SYS_CLK,
    input  wire logic               RST,
    input  wire logic               RESET_IN_PIN_N,
    input  wire logic               NMI_PIN_N,
    input  wire logic               DEBUG_RESET_PIN,
    input  wire rnsc_pkg::rnsc_cfg_t CFG_PINS,
    input  wire logic               POWER_DOWN_INSTR,
    output logic                    CORE_RESET,
    output logic                    NMI_TRAP,
    output logic                    POWER_DOWN,
    output logic                    CFG_PULLUP_EN,
    output logic                    ON_CHIP_DEBUG_EN,
    output logic                    JTAG_EN,
    output rnsc_pkg::rnsc_cfg_t      CFG_LATCHED,
    output rnsc_pkg::rnsc_mode_t     START_MODE,
    output logic                    PINS_TRISTATE
);
    localparam int CW = $clog2(RST_MIN_CYCLES + 1);

    logic [2:0]           rst_sync_reg;
    logic [2:0]           nmi_sync_reg;
    logic [2:0]           dbg_sync_reg;
    logic                 rst_low_reg;
    logic                 nmi_lvl_reg;
    logic                 dbg_lvl_reg;
    logic [CW-1:0]        low_cnt_reg;
    rnsc_pkg::rnsc_state_t state_reg;
    rnsc_pkg::rnsc_cfg_t  cfg_s1_reg;
    rnsc_pkg::rnsc_cfg_t  cfg_s2_reg;
    rnsc_pkg::rnsc_cfg_t  cfg_s3_reg;
    rnsc_pkg::rnsc_cfg_t  cfg_lvl_reg;

    function automatic rnsc_pkg::rnsc_mode_t rnsc_decode(input rnsc_pkg::rnsc_cfg_t c);
        if (c.cfg5_p9 && c.cfg4_p9)
            return rnsc_pkg::RNSC_MODE_INTERNAL;
        else if (!c.cfg5_p9 && c.cfg4_p9)
            return rnsc_pkg::RNSC_MODE_SER_BOOT;
        else if (c.cfg4_hi && c.cfg5_p9)
            return rnsc_pkg::RNSC_MODE_CAN_BOOT;
        else if (c.cfg5_hi && c.cfg4_hi)
            return rnsc_pkg::RNSC_MODE_ADAPT;
        else
            return rnsc_pkg::RNSC_MODE_TEST;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a level counts once stages two and three agree
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rst_sync_reg <= 3'h7;
            rst_low_reg  <= 1'b0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[1:0], RESET_IN_PIN_N};
            if (rst_sync_reg[1] == rst_sync_reg[2])
                rst_low_reg <= ~rst_sync_reg[2];
        end
    end

    // idle level is high, so no false falling edge follows reset
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            nmi_sync_reg <= 3'h7;
            nmi_lvl_reg  <= 1'b1;
        end else begin
            nmi_sync_reg <= {nmi_sync_reg[1:0], NMI_PIN_N};
            if (nmi_sync_reg[1] == nmi_sync_reg[2])
                nmi_lvl_reg <= nmi_sync_reg[2];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            dbg_sync_reg <= 3'h0;
            dbg_lvl_reg  <= 1'b0;
        end else begin
            dbg_sync_reg <= {dbg_sync_reg[1:0], DEBUG_RESET_PIN};
            if (dbg_sync_reg[1] == dbg_sync_reg[2])
                dbg_lvl_reg <= dbg_sync_reg[2];
        end
    end

    // config pins: same three stages; the word is taken only once it is steady,
    // so a pin still moving at release keeps the previous settled value
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            cfg_s1_reg  <= `RNSC_CFG_DEFAULT;
            cfg_s2_reg  <= `RNSC_CFG_DEFAULT;
            cfg_s3_reg  <= `RNSC_CFG_DEFAULT;
            cfg_lvl_reg <= `RNSC_CFG_DEFAULT;
        end else begin
            cfg_s1_reg <= CFG_PINS;
            cfg_s2_reg <= cfg_s1_reg;
            cfg_s3_reg <= cfg_s2_reg;
            if (cfg_s2_reg == cfg_s3_reg)
                cfg_lvl_reg <= cfg_s3_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // minimum low time
    // shorter pulses are treated as glitches and never reach the core
    always_ff @(posedge SYS_CLK) begin
        if (RST)
            low_cnt_reg <= '0;
        else if (!rst_low_reg)
            low_cnt_reg <= '0;
        else if (low_cnt_reg != CW'(RST_MIN_CYCLES))
            low_cnt_reg <= low_cnt_reg + CW'(1);
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_reg <= rnsc_pkg::RNSC_ST_RESET;
        end else begin
            unique case (state_reg)
                rnsc_pkg::RNSC_ST_RUN: begin
                    if (low_cnt_reg == CW'(RST_MIN_CYCLES))
                        state_reg <= rnsc_pkg::RNSC_ST_RESET;
                    else if (POWER_DOWN_INSTR && !nmi_lvl_reg)
                        state_reg <= rnsc_pkg::RNSC_ST_PDOWN;
                end
                rnsc_pkg::RNSC_ST_RESET: begin
                    if (!rst_low_reg)
                        state_reg <= rnsc_pkg::RNSC_ST_RUN;
                end
                rnsc_pkg::RNSC_ST_PDOWN: begin
                    // only a reset wakes power-down here
                    if (low_cnt_reg == CW'(RST_MIN_CYCLES))
                        state_reg <= rnsc_pkg::RNSC_ST_RESET;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // latch on reset release
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            CFG_LATCHED <= `RNSC_CFG_DEFAULT;
            START_MODE  <= rnsc_pkg::RNSC_MODE_INTERNAL;
        end else if (state_reg == rnsc_pkg::RNSC_ST_RESET && !rst_low_reg) begin
            if (dbg_lvl_reg) begin
                CFG_LATCHED <= cfg_lvl_reg;
                START_MODE  <= rnsc_decode(cfg_lvl_reg);
            end else begin
                CFG_LATCHED <= `RNSC_CFG_DEFAULT;
                START_MODE  <= rnsc_pkg::RNSC_MODE_INTERNAL;
            end
        end
        // otherwise held until the next reset release
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            NMI_TRAP <= 1'b0;
        end else begin
            // nmi falling edge
            // fires as the filtered level falls, so a one-sample glitch is ignored
            NMI_TRAP <= (nmi_lvl_reg && !nmi_sync_reg[1] && !nmi_sync_reg[2])
                        && state_reg == rnsc_pkg::RNSC_ST_RUN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state flags are registered so the core never sees a decode glitch
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            CORE_RESET <= 1'b1;
            POWER_DOWN <= 1'b0;
        end else begin
            CORE_RESET <= state_reg == rnsc_pkg::RNSC_ST_RESET;
            POWER_DOWN <= state_reg == rnsc_pkg::RNSC_ST_PDOWN;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST)
            CFG_PULLUP_EN <= 1'b0;
        else
            CFG_PULLUP_EN <= state_reg == rnsc_pkg::RNSC_ST_RESET && dbg_lvl_reg;
    end

    // jtag enable, no reset
    // the debug level never feeds the reset path, so raising it resets nothing
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ON_CHIP_DEBUG_EN <= 1'b0;
            JTAG_EN          <= 1'b0;
        end else begin
            ON_CHIP_DEBUG_EN <= dbg_lvl_reg;
            JTAG_EN          <= dbg_lvl_reg;
        end
    end

    // adapt mode floats the pins only once the core runs
    always_ff @(posedge SYS_CLK) begin
        if (RST)
            PINS_TRISTATE <= 1'b0;
        else
            PINS_TRISTATE <= START_MODE == rnsc_pkg::RNSC_MODE_ADAPT
                             && state_reg == rnsc_pkg::RNSC_ST_RUN;
    end
endmodule

// ---- tb/rnsc_props.sv ----
// assertion checker for the reset and start-up config block
`timescale 1ns/100ps
`include "rnsc_regs.svh"
module rnsc_props (
    input wire logic                 SYS_CLK,
    input wire logic                 RST,
    input wire logic                 RESET_IN_PIN_N,
    input wire logic                 POWER_DOWN_INSTR,
    input wire logic                 CORE_RESET,
    input wire logic                 NMI_TRAP,
    input wire logic                 POWER_DOWN,
    input wire logic                 CFG_PULLUP_EN,
    input wire logic                 ON_CHIP_DEBUG_EN,
    input wire logic                 JTAG_EN,
    input wire rnsc_pkg::rnsc_cfg_t  CFG_LATCHED,
    input wire rnsc_pkg::rnsc_mode_t START_MODE,
    input wire logic                 PINS_TRISTATE
);
    localparam int LOW_LIM = `RNSC_RST_MIN_CYCLES;
    logic [7:0] low_run_reg;
    // run of low pin samples against the real minimum, not a shortened bench one
    always_ff @(posedge SYS_CLK) begin
        if (RST || RESET_IN_PIN_N)
            low_run_reg <= 8'h00;
        else if (low_run_reg != 8'hff)
            low_run_reg <= low_run_reg + 8'h01;
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    AST_ENTER: assert property (low_run_reg == 8'(LOW_LIM) |-> ##[0:8] CORE_RESET)
        else $error("long reset pulse not taken");
    AST_TRAP_ONE: assert property (NMI_TRAP |=> !NMI_TRAP)
        else $error("trap too long");
    AST_TRAP_RUN: assert property (NMI_TRAP |-> !CORE_RESET)
        else $error("trap in reset");
    AST_PDOWN: assert property ($rose(POWER_DOWN) |->
        $past(POWER_DOWN_INSTR) || $past(POWER_DOWN_INSTR, 2)) else $error("power-down uncaused");
    AST_PULLUP: assert property (CFG_PULLUP_EN |-> CORE_RESET || $past(CORE_RESET))
        else $error("pull-ups outside reset");
    AST_HOLD: assert property (!CORE_RESET && !$past(CORE_RESET) |->
        $stable(CFG_LATCHED) && $stable(START_MODE)) else $error("config moved");
    AST_DEFAULT: assert property ($fell(CORE_RESET) && !ON_CHIP_DEBUG_EN |->
        CFG_LATCHED == `RNSC_CFG_DEFAULT && START_MODE == rnsc_pkg::RNSC_MODE_INTERNAL)
        else $error("default not latched");
    AST_TRI: assert property (PINS_TRISTATE |->
        START_MODE == rnsc_pkg::RNSC_MODE_ADAPT && !CORE_RESET) else $error("tristate outside adapt");
    AST_JTAG: assert property ($rose(JTAG_EN) |->
        $stable(CORE_RESET) && ON_CHIP_DEBUG_EN) else $error("jtag enable disturbed reset");
    cover property ($fell(CORE_RESET));
    cover property (NMI_TRAP);
    cover property ($rose(POWER_DOWN));
    cover property ($rose(PINS_TRISTATE));
endmodule
bind rnsc_top rnsc_props u_props (.*);

// ---- tb/rnsc_ext.sv ----
// model of the outside reset source and configuration resistors
`timescale 1ns/100ps
module rnsc_ext (
    input wire logic                clk,
    input wire logic                go,
    input wire logic [7:0]          hold,
    input wire rnsc_pkg::rnsc_cfg_t cfg_in,
    output logic                    pin_n,
    output rnsc_pkg::rnsc_cfg_t     cfg
);
    logic [7:0] cnt_reg = 8'h00;
    initial pin_n = 1'b1;
    initial cfg = 4'hf;
    always @(posedge clk) begin
        if (go) begin
            pin_n <= 1'b0;
            cnt_reg <= hold;
            cfg <= cfg_in;
        end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
        end else begin
            pin_n <= 1'b1;
            cfg <= cfg_in;
        end
    end
endmodule

// ---- tb/tb_reset_nmi_startup_config.sv ----
// testbench of the reset and start-up config block
`timescale 1ns/100ps
module tb_reset_nmi_startup_config;
    logic clk = 1'b0, rst = 1'b1, nmi_n = 1'b1, dbg = 1'b0, pdi = 1'b0, go = 1'b0;
    logic [7:0] hold = 8'h00;
    logic pin_n, core_rst, trap, pdown, pu, ocd, jtag, tri_st, seen_pu, seen_rst;
    rnsc_pkg::rnsc_cfg_t cfg_in = 4'hf, cfg, cfg_q;
    rnsc_pkg::rnsc_mode_t mode;
    int failures = 0, total_checks = 0, cyc = 0, n;
    rnsc_ext ext (.clk(clk), .go(go), .hold(hold), .cfg_in(cfg_in), .pin_n(pin_n), .cfg(cfg));
    rnsc_top #(.RST_MIN_CYCLES(4)) dut (.SYS_CLK(clk), .RST(rst), .RESET_IN_PIN_N(pin_n),
        .NMI_PIN_N(nmi_n), .DEBUG_RESET_PIN(dbg), .CFG_PINS(cfg), .POWER_DOWN_INSTR(pdi),
        .CORE_RESET(core_rst), .NMI_TRAP(trap), .POWER_DOWN(pdown), .CFG_PULLUP_EN(pu),
        .ON_CHIP_DEBUG_EN(ocd), .JTAG_EN(jtag), .CFG_LATCHED(cfg_q), .START_MODE(mode),
        .PINS_TRISTATE(tri_st));
    initial forever #4 clk = ~clk;
    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    // pin reset of h+1 cycles; sync depth needs the debug level a few cycles ahead
    task boot(input logic [3:0] c, input logic d, input logic [7:0] h);
        dbg <= d;
        repeat (4) @(posedge clk);
        cfg_in <= c;
        hold <= h;
        go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        seen_pu = 0;
        seen_rst = 0;
        for (n = 0; n < 90 && !(n > h + 12 && core_rst === 1'b0); n++) begin
            @(posedge clk);
            seen_pu |= pu;
            seen_rst |= core_rst;
        end
    endtask
    task t_modes;
        logic [3:0] codes[5] = '{4'h3, 4'h1, 4'h6, 4'hc, 4'h0};
        logic [4:0] exp[5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
        for (int i = 0; i < 5; i++) begin
            boot(codes[i], 1'b1, 8'd20);
            chk(seen_rst === 1'b1 && seen_pu === 1'b1, "reset or pull-ups missing");
            chk(cfg_q === codes[i] && mode === exp[i], "start mode wrong");
            chk(tri_st === (i == 3), "tristate wrong");
        end
    endtask
    task t_nmi_pdown;
        pdi <= 1'b1;
        @(posedge clk) pdi <= 1'b0;
        repeat (6) @(posedge clk);
        chk(pdown === 1'b0, "power-down with nmi high");
        nmi_n <= 1'b0;
        n = 0;
        repeat (12) @(posedge clk) n += (trap === 1'b1);
        chk(n == 1, "one trap per falling edge");
        pdi <= 1'b1;
        @(posedge clk) pdi <= 1'b0;
        repeat (6) @(posedge clk);
        chk(pdown === 1'b1, "power-down refused");
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            complete_run;
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        boot(4'h1, 1'b0, 8'd20);
        chk(cfg_q === 4'hf && mode === 5'h01 && seen_pu === 1'b0, "default start");
        cfg_in <= 4'h0;
        repeat (8) @(posedge clk);
        chk(cfg_q === 4'hf && mode === 5'h01, "config not held");
        boot(4'h6, 1'b1, 8'd2);
        chk(seen_rst === 1'b0 && cfg_q === 4'hf, "short pulse taken");
        boot(4'h3, 1'b1, 8'd3);
        chk(seen_rst === 1'b1 && cfg_q === 4'h3, "minimum pulse refused");
        t_modes();
        chk(jtag === 1'b1 && ocd === 1'b1 && core_rst === 1'b0, "debug enables");
        t_nmi_pdown();
        complete_run;
    end
endmodule
